// >>> hw/uart_tx_pkg.sv
// shared constants of the transmit path: register map, field positions,
// reset values, timing counts and the transmitter state encoding.
// assumes a 32-bit apb slave with one aligned word per register.
package uart_tx_pkg;

  // ********************************************
  // register map (byte addresses)
  // ********************************************
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] OFS_TX_HOLDING  = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_IRQ_SOURCE  = 8'h08;
  localparam logic [7:0] OFS_FIFO_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_LINE_CTRL   = 8'h10;
  localparam logic [7:0] OFS_MODEM_CTRL  = 8'h14;
  localparam logic [7:0] OFS_DIV_LOW     = 8'h18;
  localparam logic [7:0] OFS_DIV_HIGH    = 8'h1C;
  localparam logic [7:0] OFS_LINE_STATUS = 8'h20;
  localparam logic [7:0] OFS_MODE        = 8'h24;
  localparam logic [7:0] OFS_EVT_STATUS  = 8'h28;
  localparam logic [7:0] OFS_EVT_MASK    = 8'h2C;

  // ********************************************
  // field positions
  // ********************************************
  localparam int FC_ENABLE      = 0;
  localparam int FC_TX_TRIG_LSB = 8;
  localparam int FC_RX_TRIG_LSB = 16;
  localparam int TRIG_W         = 6;
  localparam int LC_WLEN_LSB    = 0;
  localparam int LC_STOP2       = 2;
  localparam int LC_PAR_EN      = 3;
  localparam int LC_PAR_EVEN    = 4;
  localparam int LC_W           = 5;
  localparam int MC_PRESCALE    = 7;
  localparam int IE_TX_EMPTY    = 1;
  localparam int IS_NONE        = 0;
  localparam int IS_TX_EMPTY    = 1;
  localparam int LS_HOLD_EMPTY  = 5;
  localparam int LS_TX_EMPTY    = 6;
  localparam int LS_LEVEL_LSB   = 8;
  localparam int MD_EIGHT_X     = 0;
  localparam int MD_AUTO_HD     = 1;
  localparam int EV_TXE         = 0;
  localparam int EV_IDLE        = 1;
  localparam int EV_OVF         = 2;
  localparam int EV_W           = 3;

  // ********************************************
  // reset values
  // ********************************************
  localparam logic [7:0]        RST_DIV       = 8'h00;
  localparam logic [TRIG_W-1:0] RST_TRIG      = 6'h20;
  localparam logic [LC_W-1:0]   RST_LINE_CTRL = 5'h03;

  // ********************************************
  // timing counts and sizes
  // ********************************************
  localparam logic [1:0] PRESCALE_LAST  = 2'h3;
  localparam logic [3:0] TICKS_16X_LAST = 4'hF;
  localparam logic [3:0] TICKS_8X_LAST  = 4'h7;
  localparam logic [2:0] WLEN_MIN_LAST  = 3'h4;
  localparam logic [6:0] FIFO_DEPTH     = 7'h40;
  localparam logic [6:0] HOLD_DEPTH     = 7'h01;

  typedef enum logic [4:0] {
    TX_IDLE   = 5'b00001,
    TX_START  = 5'b00010,
    TX_DATA   = 5'b00100,
    TX_PARITY = 5'b01000,
    TX_STOP   = 5'b10000
  } tx_state_t;

endpackage : uart_tx_pkg

// >>> hw/baud_link_if.sv
// carries the divisor and prescale choice to the rate divider and the
// sampling tick back; both ends run on clk_sys.
`timescale 1ns/1ns
interface baud_link_if;
  logic [15:0] divisor;
  logic        prescale_by4;
  logic        tick;
  modport rate_src  (input divisor, input prescale_by4, output tick);
  modport rate_user (output divisor, output prescale_by4, input tick);
endinterface : baud_link_if

// >>> hw/rate_divider.sv
// prescaler and programmable rate divider producing the sampling tick.
// assumes divisor and prescale come from registers on the same clock.
`timescale 1ns/1ns
module rate_divider
  import uart_tx_pkg::*;
(
  input wire logic   clk_sys,
  input wire logic   reset,
  baud_link_if.rate_src link
);

  typedef struct packed {
    logic [1:0]  pre_cnt;
    logic [15:0] div_cnt;
    logic        tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic       pre_tick;

  // ********************************************
  // divide chain
  // ********************************************
  // prescaler passes every clock or every fourth, then the divisor counts
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    pre_tick     = 1'b1;
    if (link.prescale_by4)
    begin
      pre_tick = (st.pre_cnt == PRESCALE_LAST);
    end
    next_st.pre_cnt = st.pre_cnt + 2'h1;
    // a zero divisor stops the tick; the host must program it first
    if (pre_tick && link.divisor != 16'h0000)
    begin
      if (st.div_cnt >= link.divisor - 16'h0001)
      begin
        next_st.div_cnt = 16'h0000;
        next_st.tick    = 1'b1;
      end
      else
      begin
        next_st.div_cnt = st.div_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.tick = st.tick;

endmodule : rate_divider

// >>> hw/uart_tx_baud_and_irq_pin.sv
// one transmit channel: apb registers, 64-byte fifo, serial framing,
// line status, interrupt events and the service pin level.
// assumes apb master on clk_sys and a receiver that reports its fifo level.
`timescale 1ns/1ns

module uart_tx_baud_and_irq_pin
  import uart_tx_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [6:0]  rx_fifo_level,
  output logic             serial_out,
  output logic             sample_tick,
  output logic             service_pin,
  output logic             irq
);

  typedef struct packed {
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  tx_irq_en;
    logic                  fifo_en;
    logic [TRIG_W-1:0]     tx_trig;
    logic [TRIG_W-1:0]     rx_trig;
    logic [LC_W-1:0]       line_ctrl;
    logic                  prescale;
    logic [7:0]            div_low;
    logic [7:0]            divisor_high;
    logic                  eight_x;
    logic                  auto_hd;
    logic [EV_W-1:0]       evt;
    logic [EV_W-1:0]       mask;
    logic [63:0][7:0]      mem;
    logic [5:0]            wr_ptr;
    logic [5:0]            rd_ptr;
    logic [6:0]            count;
    tx_state_t             state;
    logic [7:0]            shift;
    logic [2:0]            bit_idx;
    logic [3:0]            samp_cnt;
    logic                  stop_cnt;
    logic                  par_acc;
    logic                  txd;
    logic                  tick;
    logic                  tx_pin;
    logic                  rx_pin;
    logic                  pin;
    logic                  txe_int_d;
    logic                  idle_d;
    logic                  irq;
  } tx_state_all_t;

  tx_state_all_t st;
  tx_state_all_t next_st;
  baud_link_if   baud ();

  logic [7:0]      addr;
  logic            wr_en;
  logic            push;
  logic            pop;
  logic            full;
  logic            hold_empty;
  logic            tx_empty;
  logic            txe_int;
  logic [6:0]      tx_trig7;
  logic [6:0]      rx_trig7;
  logic [3:0]      last_tick;
  logic [2:0]      last_bit;
  logic            par_new;
  logic [EV_W-1:0] ev;
  logic [31:0]     rd_val;
  logic            rd_ok;

  // ********************************************
  // rate divider
  // ********************************************
  assign baud.divisor      = {st.divisor_high, st.div_low};
  assign baud.prescale_by4 = st.prescale;

  rate_divider u_rate_divider
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .link    (baud.rate_src)
  );

  // ********************************************
  // status terms
  // ********************************************
  // holding and fifo share one array; without fifo only one entry is held at a time
  assign full       = (st.count == (st.fifo_en ? FIFO_DEPTH : HOLD_DEPTH));
  assign hold_empty = (st.count == 7'h00);
  assign tx_empty   = hold_empty && (st.state == TX_IDLE);
  assign tx_trig7   = {1'b0, st.tx_trig};
  assign rx_trig7   = {1'b0, st.rx_trig};
  // fifo mode flags the holding side empty once below the trigger level
  assign txe_int    = st.tx_irq_en &&
                      (st.fifo_en ? (st.count < tx_trig7) : hold_empty);
  assign last_tick  = st.eight_x ? TICKS_8X_LAST : TICKS_16X_LAST;
  assign last_bit   = st.line_ctrl[LC_WLEN_LSB +: 2] + WLEN_MIN_LAST;
  assign addr       = paddr[7:0];
  assign wr_en      = psel && penable && pready && pwrite;

  // ********************************************
  // read mux
  // ********************************************
  // unmapped addresses answer with an error and zero data; upper addresses err but read the register their low byte selects
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = (paddr[31:8] == 24'h00_0000);
    unique case (addr)
      OFS_TX_HOLDING:  rd_val = 32'h0000_0000;
      OFS_IRQ_ENABLE:  rd_val[IE_TX_EMPTY] = st.tx_irq_en;
      OFS_IRQ_SOURCE:
      begin
        rd_val[IS_NONE]     = ~txe_int;
        rd_val[IS_TX_EMPTY] = txe_int;
      end
      OFS_FIFO_CTRL:
      begin
        rd_val[FC_ENABLE]                = st.fifo_en;
        rd_val[FC_TX_TRIG_LSB +: TRIG_W] = st.tx_trig;
        rd_val[FC_RX_TRIG_LSB +: TRIG_W] = st.rx_trig;
      end
      OFS_LINE_CTRL:   rd_val[LC_W-1:0]   = st.line_ctrl;
      OFS_MODEM_CTRL:  rd_val[MC_PRESCALE] = st.prescale;
      OFS_DIV_LOW:     rd_val[7:0]        = st.div_low;
      OFS_DIV_HIGH:    rd_val[7:0]        = st.divisor_high;
      OFS_LINE_STATUS:
      begin
        rd_val[LS_HOLD_EMPTY]     = hold_empty;
        rd_val[LS_TX_EMPTY]       = tx_empty;
        rd_val[LS_LEVEL_LSB +: 7] = st.count;
      end
      OFS_MODE:
      begin
        rd_val[MD_EIGHT_X] = st.eight_x;
        rd_val[MD_AUTO_HD] = st.auto_hd;
      end
      OFS_EVT_STATUS:  rd_val[EV_W-1:0] = st.evt;
      OFS_EVT_MASK:    rd_val[EV_W-1:0] = st.mask;
      default:         rd_ok = 1'b0;
    endcase
  end

  // ********************************************
  // next state
  // ********************************************
  always_comb
  begin
    next_st        = st;
    push           = 1'b0;
    pop            = 1'b0;
    par_new        = 1'b0;
    ev             = '0;
    // apb answers in the first access cycle; pready is a flop
    next_st.pready = psel && !penable;
    if (psel && !penable)
    begin
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      next_st.pslverr = ~rd_ok;
    end
    // the answer stands for the access cycle only, so error and data never linger
    else
    begin
      next_st.prdata  = 32'h0000_0000;
      next_st.pslverr = 1'b0;
    end
    // register writes take effect at the completing edge only
    if (wr_en && !st.pslverr)
    begin
      unique case (addr)
        OFS_TX_HOLDING:
        begin
          if (full)
          begin
            ev[EV_OVF] = 1'b1;
          end
          else
          begin
            push                    = 1'b1;
            next_st.mem[st.wr_ptr]  = pwdata[7:0];
            next_st.wr_ptr          = st.wr_ptr + 6'h01;
          end
        end
        OFS_IRQ_ENABLE:  next_st.tx_irq_en = pwdata[IE_TX_EMPTY];
        OFS_FIFO_CTRL:
        begin
          next_st.fifo_en = pwdata[FC_ENABLE];
          next_st.tx_trig = pwdata[FC_TX_TRIG_LSB +: TRIG_W];
          next_st.rx_trig = pwdata[FC_RX_TRIG_LSB +: TRIG_W];
        end
        OFS_LINE_CTRL:   next_st.line_ctrl    = pwdata[LC_W-1:0];
        OFS_MODEM_CTRL:  next_st.prescale     = pwdata[MC_PRESCALE];
        OFS_DIV_LOW:     next_st.div_low      = pwdata[7:0];
        OFS_DIV_HIGH:    next_st.divisor_high = pwdata[7:0];
        OFS_MODE:
        begin
          next_st.eight_x = pwdata[MD_EIGHT_X];
          next_st.auto_hd = pwdata[MD_AUTO_HD];
        end
        OFS_EVT_MASK:    next_st.mask = pwdata[EV_W-1:0];
        default:         next_st.mask = st.mask;
      endcase
    end

    // transmitter: one shared tick drives the bit timing
    next_st.tick = baud.tick;
    unique case (st.state)
      TX_IDLE:
      begin
        next_st.txd = 1'b1;
        if (!hold_empty)
        begin
          pop              = 1'b1;
          next_st.shift    = st.mem[st.rd_ptr];
          next_st.rd_ptr   = st.rd_ptr + 6'h01;
          next_st.state    = TX_START;
          next_st.txd      = 1'b0;
          next_st.samp_cnt = 4'h0;
          next_st.bit_idx  = 3'h0;
          next_st.par_acc  = 1'b0;
          next_st.stop_cnt = 1'b0;
        end
      end
      TX_START, TX_DATA, TX_PARITY, TX_STOP:
      begin
        if (st.tick)
        begin
          next_st.samp_cnt = st.samp_cnt + 4'h1;
          // a bit lasts last_tick+1 sampling ticks
          if (st.samp_cnt == last_tick)
          begin
            next_st.samp_cnt = 4'h0;
            unique case (st.state)
              TX_START:
              begin
                next_st.state = TX_DATA;
                next_st.txd   = st.shift[0];
              end
              TX_DATA:
              begin
                par_new         = st.par_acc ^ st.shift[0];
                next_st.par_acc = par_new;
                next_st.shift   = {1'b0, st.shift[7:1]};
                if (st.bit_idx == last_bit)
                begin
                  if (st.line_ctrl[LC_PAR_EN])
                  begin
                    next_st.state = TX_PARITY;
                    next_st.txd   = st.line_ctrl[LC_PAR_EVEN] ? par_new : ~par_new;
                  end
                  else
                  begin
                    next_st.state = TX_STOP;
                    next_st.txd   = 1'b1;
                  end
                end
                else
                begin
                  next_st.bit_idx = st.bit_idx + 3'h1;
                  next_st.txd     = st.shift[1];
                end
              end
              TX_PARITY:
              begin
                next_st.state = TX_STOP;
                next_st.txd   = 1'b1;
              end
              default:
              begin
                if (st.stop_cnt == st.line_ctrl[LC_STOP2])
                begin
                  next_st.state = TX_IDLE;
                end
                else
                begin
                  next_st.stop_cnt = 1'b1;
                end
              end
            endcase
          end
        end
      end
      default:
      begin
        next_st.state = TX_IDLE;
        next_st.txd   = 1'b1;
      end
    endcase

    // occupancy follows both ends in one step
    next_st.count = st.count + {6'h00, push} - {6'h00, pop};
    // changing fifo mode empties the storage so the modes never mix
    if (wr_en && !st.pslverr && addr == OFS_FIFO_CTRL &&
        pwdata[FC_ENABLE] != st.fifo_en)
    begin
      next_st.wr_ptr = 6'h00;
      next_st.rd_ptr = 6'h00;
      next_st.count  = 7'h00;
    end

    // transmit side of the service pin; equal to trigger holds the level unless hold_empty, or tx_empty with auto_hd
    if (!st.fifo_en)
    begin
      next_st.tx_pin = !hold_empty;
    end
    else if (st.auto_hd)
    begin
      if (st.count < tx_trig7 || tx_empty)
      begin
        next_st.tx_pin = 1'b0;
      end
      else if (st.count > tx_trig7)
      begin
        next_st.tx_pin = 1'b1;
      end
    end
    else
    begin
      if (st.count < tx_trig7 || hold_empty)
      begin
        next_st.tx_pin = 1'b0;
      end
      else if (st.count > tx_trig7)
      begin
        next_st.tx_pin = 1'b1;
      end
    end
    // receive side; without fifo it never pulls the pin low
    if (!st.fifo_en)
    begin
      next_st.rx_pin = 1'b1;
    end
    else if (rx_fifo_level < rx_trig7)
    begin
      next_st.rx_pin = 1'b1;
    end
    else if (rx_fifo_level > rx_trig7)
    begin
      next_st.rx_pin = 1'b0;
    end
    // low on either side calls for service
    next_st.pin = st.tx_pin && st.rx_pin;

    // sticky events: a new event wins over a clearing write
    next_st.txe_int_d = txe_int;
    next_st.idle_d    = tx_empty;
    ev[EV_TXE]        = txe_int && !st.txe_int_d;
    ev[EV_IDLE]       = tx_empty && !st.idle_d;
    if (wr_en && !st.pslverr && addr == OFS_EVT_STATUS)
    begin
      next_st.evt = st.evt & ~pwdata[EV_W-1:0];
    end
    next_st.evt = next_st.evt | ev;
    next_st.irq = |(st.evt & st.mask);
  end

  // ********************************************
  // state register
  // ********************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      next_st_reset_block:
      begin
        st              <= '0;
        st.tx_trig      <= RST_TRIG;
        st.rx_trig      <= RST_TRIG;
        st.line_ctrl    <= RST_LINE_CTRL;
        st.div_low      <= RST_DIV;
        st.divisor_high <= RST_DIV;
        st.state        <= TX_IDLE;
        st.txd          <= 1'b1;
        st.rx_pin       <= 1'b1;
        st.idle_d       <= 1'b1;
      end
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs come straight from the state flops
  assign pready      = st.pready;
  assign prdata      = st.prdata;
  assign pslverr     = st.pslverr;
  assign serial_out  = st.txd;
  assign sample_tick = st.tick;
  assign service_pin = st.pin;
  assign irq         = st.irq;

endmodule : uart_tx_baud_and_irq_pin

// >>> verification/uart_tx_props.sv
// port checker of the transmit channel, bound into its top module.
// assumes a single clock domain clk_sys and reset active high.
`timescale 1ns/1ns
module uart_tx_props
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out,
  input wire logic sample_tick,
  input wire logic service_pin,
  input wire logic irq
);
  // ********************************************
  // port relations
  // ********************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // bus answer: one wait-free cycle, only inside an access
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  // the start edge is not tick aligned, so only rising edges are tied to ticks
  a_rise_on_tick:
    assert property ($rose(serial_out) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("line edge off tick");
  // divisor comes up zero, so no tick and an idle line after release
  a_line_idle_reset:
    assert property ($fell(reset) |-> serial_out && !sample_tick) else $error("line busy");
  a_pin_low_reset: assert property ($fell(reset) |-> !service_pin) else $error("pin high");
  a_irq_quiet_reset: assert property ($fell(reset) |-> !irq) else $error("irq high");
  c_frame: cover property ($fell(serial_out));
  c_refused: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_pin: cover property ($fell(service_pin));
endmodule : uart_tx_props
bind uart_tx_baud_and_irq_pin uart_tx_props u_uart_tx_props (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .serial_out(serial_out), .sample_tick(sample_tick),
  .service_pin(service_pin), .irq(irq));

// >>> verification/serial_sink.sv
// remote receiver model: turns the serial line into a frame of bits.
// assumes sixteen sampling ticks a bit and a line that idles high.
`timescale 1ns/1ns
module serial_sink
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        line,
  input  wire logic        tick,
  input  wire logic [3:0]  nbits,
  output logic      [11:0] frame,
  output logic             done
);
  logic       busy;
  logic [7:0] cnt;
  // ********************************************
  // frame capture
  // ********************************************
  // phase counts from the first tick; the start edge falls between ticks
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      busy  <= 1'b0;
      cnt   <= 8'h00;
      frame <= 12'h000;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy)
      begin
        busy <= !line;
        cnt  <= 8'h00;
      end
      else if (tick)
      begin
        cnt <= cnt + 8'h01;
        if (cnt[3:0] == 4'h7)
        begin
          frame[cnt[7:4]] <= line;
          busy            <= cnt[7:4] != nbits - 4'h1;
          done            <= cnt[7:4] == nbits - 4'h1;
        end
      end
    end
  end
endmodule : serial_sink

// >>> verification/test_uart_tx_baud_and_irq_pin.sv
// self-checking bench of one transmit channel and a remote receiver model.
// assumes the register map and field layout of the channel package.
`timescale 1ns/1ns
module test_uart_tx_baud_and_irq_pin
  import uart_tx_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  rx_fifo_level = 7'h00;
  logic [3:0]  nbits = 4'hB;
  logic        pready, pslverr, serial_out, sample_tick, service_pin, irq, done, err;
  logic [31:0] prdata, rd;
  logic [11:0] frame;
  int          errors = 0;
  int          check_count = 0;
  // ********************************************
  // harness and scenarios
  // ********************************************
  uart_tx_baud_and_irq_pin u_uart_tx_baud_and_irq_pin (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_fifo_level(rx_fifo_level), .serial_out(serial_out), .sample_tick(sample_tick),
    .service_pin(service_pin), .irq(irq));
  serial_sink u_serial_sink (
    .clk_sys(clk_sys), .reset(reset), .line(serial_out), .tick(sample_tick),
    .nbits(nbits), .frame(frame), .done(done));
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // the request stands until the edge that samples pready high; data is taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {24'h0, a};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // spacing of sampling ticks; the first two gaps may straddle a divisor change
  task automatic per(input int exp);
    int n;
    repeat (3)
    begin
      n = 0;
      do
      begin
        @(negedge clk_sys);
        n++;
      end
      while (sample_tick !== 1'b1 && n < 5000);
    end
    chk(n, exp);
  endtask : per
  task automatic t_regs;
    apb(1'b0, OFS_FIFO_CTRL, 32'h0);
    chk(rd, {10'h0, RST_TRIG, 2'h0, RST_TRIG, 8'h0});
    apb(1'b1, OFS_LINE_STATUS, 32'h0);
    apb(1'b0, OFS_LINE_STATUS, 32'h0);
    chk(rd, 32'h60);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_regs
  task automatic t_div;
    apb(1'b1, OFS_DIV_LOW, 32'h00);
    apb(1'b1, OFS_DIV_HIGH, 32'h09);
    per(2304);
    apb(1'b1, OFS_DIV_HIGH, 32'h00);
    apb(1'b1, OFS_DIV_LOW, 32'h03);
    apb(1'b1, OFS_MODEM_CTRL, 32'h80);
    per(12);
    apb(1'b1, OFS_MODEM_CTRL, 32'h00);
    apb(1'b1, OFS_DIV_LOW, 32'h01);
    per(1);
  endtask : t_div
  // even parity, odd parity with two stops, five bits plain
  task automatic t_frame;
    logic [7:0]  lc [3] = '{8'h1B, 8'h0E, 8'h00};
    logic [7:0]  db [3] = '{8'hA5, 8'h5A, 8'h13};
    logic [3:0]  nb [3] = '{4'hB, 4'hB, 4'h7};
    logic [11:0] ex [3] = '{12'h54A, 12'h7B4, 12'h066};
    for (int i = 0; i < 3; i++)
    begin
      nbits <= nb[i];
      apb(1'b1, OFS_LINE_CTRL, {24'h0, lc[i]});
      apb(1'b1, OFS_TX_HOLDING, {24'h0, db[i]});
      apb(1'b0, OFS_LINE_STATUS, 32'h0);
      chk(rd, 32'h20);
      do @(negedge clk_sys); while (done !== 1'b1);
      chk(frame & ((12'h1 << nb[i]) - 12'h1), ex[i]);
      repeat (30) @(negedge clk_sys);
    end
    apb(1'b0, OFS_LINE_STATUS, 32'h0);
    chk(rd, 32'h60);
  endtask : t_frame
  task automatic t_irq;
    apb(1'b0, OFS_IRQ_SOURCE, 32'h0);
    chk(rd, 32'h01);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h02);
    apb(1'b0, OFS_IRQ_SOURCE, 32'h0);
    chk(rd, 32'h02);
    chk(irq, 1'b0);
    apb(1'b1, OFS_EVT_MASK, 32'h03);
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b1);
    apb(1'b1, OFS_EVT_STATUS, 32'h07);
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b0);
  endtask : t_irq
  // eight ticks a bit; in half-duplex mode the pin stays up until the shifter drains
  task automatic t_mode;
    int n;
    apb(1'b1, OFS_MODE, 32'h3);
    apb(1'b1, OFS_FIFO_CTRL, 32'h00200001);
    apb(1'b1, OFS_TX_HOLDING, 32'h01);
    do @(negedge clk_sys); while (serial_out !== 1'b0);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (serial_out === 1'b0 && n < 100);
    chk(n, 8);
    chk(service_pin, 1'b1);
    repeat (60) @(negedge clk_sys);
    chk(service_pin, 1'b0);
    apb(1'b1, OFS_MODE, 32'h0);
    apb(1'b1, OFS_FIFO_CTRL, 32'h0);
  endtask : t_mode
  // slow line keeps the fifo filling; the first byte leaves for the shifter at once
  task automatic t_fifo;
    apb(1'b1, OFS_DIV_LOW, 32'hFF);
    apb(1'b1, OFS_FIFO_CTRL, 32'h00200401);
    for (int i = 0; i < 70; i++)
    begin
      apb(1'b1, OFS_TX_HOLDING, i);
      if (i == 9)
      begin
        apb(1'b0, OFS_LINE_STATUS, 32'h0);
        chk(rd, 32'h0900);
        chk(service_pin, 1'b1);
        rx_fifo_level <= 7'h28;
        repeat (4) @(negedge clk_sys);
        chk(service_pin, 1'b0);
        @(posedge clk_sys);
        rx_fifo_level <= 7'h00;
      end
    end
    apb(1'b0, OFS_LINE_STATUS, 32'h0);
    chk(rd, 32'h4000);
    apb(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b1, OFS_FIFO_CTRL, 32'h00200400);
    apb(1'b0, OFS_LINE_STATUS, 32'h0);
    chk(rd, 32'h20);
    chk(service_pin, 1'b0);
  endtask : t_fifo
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_div();
    t_frame();
    t_irq();
    t_mode();
    t_fifo();
    end_sim();
  end
  // the run needs some 8000 cycles; this allows 60000, over seven times that
  initial
  begin
    #600000;
    errors++;
    end_sim();
  end
endmodule : test_uart_tx_baud_and_irq_pin
